/* logic/cbp_defines.vh */
// Constants for the cell balancing and protector control block.
// Included by the register bank only; holds definitions only.
// Function
// - Sixteen per-cell 5-bit timer codes, zero means stop, captured at balancing start.
// - Module timer code captured at start; codes 1..4 are 10, 30, 60, 300 s.
// - Codes 5..16 give 10..120 min, 17..30 give 150..540 min, 31 gives 600 min.
// - Balancing overtemperature level is 4 bits, saturating at 24 percent.
// - Cool-off is 3 bits up to 14 percent; resume below level minus cool-off.
// - Duty code captured at start maps 0..7 to 5 s up to 30 min.
// - Both completion registers clear at start; a cell's flag sets when it finishes.
// - Remaining time readback: unit bit zero is 5 s steps, one is 5 min steps.
// - Exclusion bit removes a cell from undervoltage and done-voltage monitoring.
// - Undertemperature level spans 66..80 percent in 2 percent steps, reset 80 percent.
// - Overtemperature level spans 10..39 percent in 1 percent steps, unused codes 39.
// - In lock mode the 4-bit channel code picks cell 1 through cell 16.
// - Voltage start captures all voltage comparator settings, starts them, self-clears.
// - Voltage mode: 00 stop, 01 round robin, 10 self-test, 11 single channel.
`ifndef CBP_DEFINES_VH
`define CBP_DEFINES_VH

`define CBP_IDX_OV_THR 11'h009
`define CBP_IDX_UV_THR 11'h00a
`define CBP_IDX_TEMP_THR 11'h00b
`define CBP_IDX_UV_EXCL_HI 11'h00c
`define CBP_IDX_UV_EXCL_LO 11'h00d
`define CBP_IDX_CELL_TMR_FIRST 11'h318
`define CBP_IDX_CELL_TMR_LAST 11'h327
`define CBP_IDX_MOD_DONE_THR 11'h328
`define CBP_IDX_MOD_TMR 11'h329
`define CBP_IDX_CELL_DONE_THR 11'h32a
`define CBP_IDX_BAL_OVERTEMPERATURE_LEVEL 11'h32b
`define CBP_IDX_VCMP_CTRL 11'h32c
`define CBP_IDX_TCMP_CTRL 11'h32d
`define CBP_IDX_BAL_DUTY 11'h32e
`define CBP_IDX_BAL_MAIN 11'h32f
`define CBP_IDX_BAL_QUERY 11'h330
`define CBP_IDX_DONE_HI 11'h556
`define CBP_IDX_DONE_LO 11'h557
`define CBP_IDX_REM_TIME 11'h558

`define CBP_RST_OV_THR 8'h3f
`define CBP_RST_UV_THR 8'h00
`define CBP_RST_TEMP_THR 8'hfd
`define CBP_RST_DONE_THR 8'h3f
`define CBP_RST_BAL_OVERTEMPERATURE_LEVEL 8'h0f
`define CBP_RST_ZERO 8'h00

`define CBP_BIT_VCMP_START 2
`define CBP_BIT_TCMP_START 2
`define CBP_BIT_BAL_START 1
`define CBP_BIT_BAL_AUTO 0
`define CBP_BIT_BAL_OTEN 4
`define CBP_BIT_BAL_PAUSE 6
`define CBP_BIT_QUERY_START 0

`define CBP_MODE_STOP 2'b00
`define CBP_MODE_ROBIN 2'b01
`define CBP_MODE_SELFTEST 2'b10
`define CBP_MODE_LOCK 2'b11

`define CBP_CLK_HZ 20000000
`define CBP_TICK_S 1
`define CBP_SEC_UNIT_MAX 16'd635

`endif

/* logic/cbp_timer_mem.v */
// Sixteen-entry store for the per-cell balancing timer codes.
// One shared port; read data is registered and appears one edge after the address.
`timescale 1ns/1ps
module cbp_timer_mem (
  input wire clk_i,
  input wire ce_i,
  input wire we_i,
  input wire [3:0] addr_i,
  input wire [4:0] wdata_i,
  output reg [4:0] rdata_o
);
  reg [4:0] mem_q [0:15];

  always @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem_q[addr_i] <= wdata_i;
      end
      rdata_o <= mem_q[addr_i];
    end
  end
endmodule

/* logic/cbp_ctrl.v */
// Register bank and balancing timers for the cell balancing and protector controls.
// Assumes an AHB-Lite master on CLK_I and asynchronous comparator and sensor inputs.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "cbp_defines.vh"
module cbp_ctrl #(
  parameter TICK_CYCLES = `CBP_CLK_HZ * `CBP_TICK_S
) (
  input wire CLK_I,
  input wire SRST_I,
  input wire CE_I,
  input wire HSEL_I,
  input wire [31:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output reg HREADYOUT_O,
  output reg HRESP_O,
  input wire [15:0] CELL_DONE_VOLTAGE_I,
  input wire [6:0] THERM_PCT_I,
  output reg [15:0] CELL_BAL_O,
  output reg MODULE_BAL_O,
  output reg BAL_PAUSED_O,
  output reg BAL_AUTO_O,
  output reg VCMP_RUN_O,
  output reg VCMP_SELFTEST_O,
  output reg [3:0] VCMP_CHAN_O,
  output reg [5:0] OV_THR_O,
  output reg [5:0] UV_THR_O,
  output reg [15:0] UV_MON_O,
  output reg [5:0] CELL_DONE_THR_O,
  output reg TCMP_RUN_O,
  output reg TCMP_SELFTEST_O,
  output reg [2:0] TCMP_CHAN_O,
  output reg [6:0] OT_PCT_O,
  output reg [6:0] UT_PCT_O
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LOAD = 3'b010;
  localparam ST_RUN = 3'b100;

  // Timer code to seconds.
  function [15:0] f_code_sec;
    input [4:0] code;
    begin
      case (code)
        5'h00: f_code_sec = 16'd0;
        5'h01: f_code_sec = 16'd10;
        5'h02: f_code_sec = 16'd30;
        5'h03: f_code_sec = 16'd60;
        5'h04: f_code_sec = 16'd300;
        5'h1f: f_code_sec = 16'd36000;
        default: begin
          if (code <= 5'h10) begin
            f_code_sec = {11'd0, code - 5'd4} * 16'd600;
          end else begin
            f_code_sec = 16'd9000 + {11'd0, code - 5'h11} * 16'd1800;
          end
        end
      endcase
    end
  endfunction

  function [10:0] f_duty_sec;
    input [2:0] code;
    begin
      case (code)
        3'h0: f_duty_sec = 11'd5;
        3'h1: f_duty_sec = 11'd10;
        3'h2: f_duty_sec = 11'd30;
        3'h3: f_duty_sec = 11'd60;
        3'h4: f_duty_sec = 11'd300;
        3'h5: f_duty_sec = 11'd600;
        3'h6: f_duty_sec = 11'd1200;
        default: f_duty_sec = 11'd1800;
      endcase
    end
  endfunction

  // Remaining seconds to unit bit and 7-bit count, rounded up.
  function [7:0] f_report;
    input [15:0] secs;
    reg [15:0] q;
    begin
      q = 16'd0;
      if (secs <= `CBP_SEC_UNIT_MAX) begin
        q = (secs + 16'd4) / 16'd5;
        f_report = {1'b0, q[6:0]};
      end else begin
        q = (secs + 16'd299) / 16'd300;
        f_report = {1'b1, q[6:0]};
      end
    end
  endfunction

  reg [7:0] ov_thr_q, uv_thr_q, temp_thr_q, excl_hi_q, excl_lo_q;
  reg [7:0] mod_done_thr_q, mod_tmr_q, cell_done_thr_q, bal_overtemperature_level_q;
  reg [7:0] vcmp_ctrl_q, tcmp_ctrl_q, bal_duty_q, bal_main_q, bal_query_q;
  reg [15:0] done_q;
  reg [7:0] rem_time_q;
  reg [2:0] st_q;
  reg [4:0] load_idx_q;
  reg [15:0] cnt_q [0:15];
  reg [15:0] mod_cnt_q;
  reg [24:0] tick_cnt_q;
  reg tick_q;
  reg [10:0] duty_cnt_q;
  reg [10:0] duty_len_q;
  reg phase_q;
  reg auto_q;
  reg oten_q;
  reg ot_hold_q;
  reg [1:0] vmode_q;
  reg [3:0] vlock_q;
  reg [1:0] tmode_q;
  reg [2:0] tlock_q;
  reg [15:0] excl_cap_q;
  reg [15:0] cdv_s1_q, cdv_s2_q;
  reg [6:0] th_s1_q, th_s2_q;
  reg [1:0] bstg_q;
  reg [10:0] bidx_q;
  reg bwrite_q;
  integer i;
  integer j;

  wire b_take = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire loading = st_q[1];
  wire b_in_mem = (bidx_q >= `CBP_IDX_CELL_TMR_FIRST) && (bidx_q <= `CBP_IDX_CELL_TMR_LAST);
  wire [10:0] b_mem_off = bidx_q - `CBP_IDX_CELL_TMR_FIRST;
  wire b_wr = (bstg_q == 2'd1) && !loading && bwrite_q;
  wire mem_we = b_wr && b_in_mem;
  wire [3:0] mem_addr = loading ? load_idx_q[3:0] : b_mem_off[3:0];
  wire [4:0] mem_rdata;
  wire [7:0] wd = HWDATA_I[7:0];
  wire bal_start = b_wr && (bidx_q == `CBP_IDX_BAL_MAIN) && wd[`CBP_BIT_BAL_START];
  wire vcmp_start = b_wr && (bidx_q == `CBP_IDX_VCMP_CTRL) && wd[`CBP_BIT_VCMP_START];
  wire tcmp_start = b_wr && (bidx_q == `CBP_IDX_TCMP_CTRL) && wd[`CBP_BIT_TCMP_START];
  wire query_start = b_wr && (bidx_q == `CBP_IDX_BAL_QUERY) && wd[`CBP_BIT_QUERY_START];
  wire [6:0] balance_overtemperature_pct = (bal_overtemperature_level_q[3:0] > 4'd7) ? 7'd24 : 7'd10 + {2'd0, bal_overtemperature_level_q[3:0], 1'b0};
  wire [6:0] cool_pct = {3'd0, bal_overtemperature_level_q[6:4], 1'b0};
  wire paused = bal_main_q[`CBP_BIT_BAL_PAUSE] | ot_hold_q;
  wire [15:0] excl_live = {excl_hi_q, excl_lo_q};
  wire [4:0] load_cell = 5'd16 - load_idx_q;

  cbp_timer_mem cbp_timer_mem_i (
    .clk_i(CLK_I),
    .ce_i(CE_I),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(HWDATA_I[4:0]),
    .rdata_o(mem_rdata)
  );

  // Bus slave with one wait state on writes and two on reads; transfers wait longer while timer codes load.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      bstg_q <= 2'd0;
      bidx_q <= 11'd0;
      bwrite_q <= 1'b0;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      HRDATA_O <= 32'h0000_0000;
    end else if (CE_I) begin
      HRESP_O <= 1'b0;
      if (bstg_q == 2'd0) begin
        if (b_take) begin
          bidx_q <= HADDR_I[12:2];
          bwrite_q <= HWRITE_I;
          bstg_q <= 2'd1;
          HREADYOUT_O <= 1'b0;
        end
      end else if (bstg_q == 2'd1) begin
        if (!loading) begin
          if (bwrite_q) begin
            bstg_q <= 2'd0;
            HREADYOUT_O <= 1'b1;
          end else begin
            bstg_q <= 2'd2;
          end
        end
      end else begin
        bstg_q <= 2'd0;
        HREADYOUT_O <= 1'b1;
        if (b_in_mem) begin
          HRDATA_O <= {27'd0, mem_rdata};
        end else begin
          case (bidx_q)
            `CBP_IDX_OV_THR: HRDATA_O <= {24'd0, ov_thr_q};
            `CBP_IDX_UV_THR: HRDATA_O <= {24'd0, uv_thr_q};
            `CBP_IDX_TEMP_THR: HRDATA_O <= {24'd0, temp_thr_q};
            `CBP_IDX_UV_EXCL_HI: HRDATA_O <= {24'd0, excl_hi_q};
            `CBP_IDX_UV_EXCL_LO: HRDATA_O <= {24'd0, excl_lo_q};
            `CBP_IDX_MOD_DONE_THR: HRDATA_O <= {24'd0, mod_done_thr_q};
            `CBP_IDX_MOD_TMR: HRDATA_O <= {24'd0, mod_tmr_q};
            `CBP_IDX_CELL_DONE_THR: HRDATA_O <= {24'd0, cell_done_thr_q};
            `CBP_IDX_BAL_OVERTEMPERATURE_LEVEL: HRDATA_O <= {24'd0, bal_overtemperature_level_q};
            `CBP_IDX_VCMP_CTRL: HRDATA_O <= {24'd0, vcmp_ctrl_q};
            `CBP_IDX_TCMP_CTRL: HRDATA_O <= {24'd0, tcmp_ctrl_q};
            `CBP_IDX_BAL_DUTY: HRDATA_O <= {24'd0, bal_duty_q};
            `CBP_IDX_BAL_MAIN: HRDATA_O <= {24'd0, bal_main_q};
            `CBP_IDX_BAL_QUERY: HRDATA_O <= {24'd0, bal_query_q};
            `CBP_IDX_DONE_HI: HRDATA_O <= {24'd0, done_q[15:8]};
            `CBP_IDX_DONE_LO: HRDATA_O <= {24'd0, done_q[7:0]};
            `CBP_IDX_REM_TIME: HRDATA_O <= {24'd0, rem_time_q};
            default: HRDATA_O <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Software-written registers; start bits are never stored so they read back zero.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      ov_thr_q <= `CBP_RST_OV_THR;
      uv_thr_q <= `CBP_RST_UV_THR;
      temp_thr_q <= `CBP_RST_TEMP_THR;
      excl_hi_q <= `CBP_RST_ZERO;
      excl_lo_q <= `CBP_RST_ZERO;
      mod_done_thr_q <= `CBP_RST_DONE_THR;
      mod_tmr_q <= `CBP_RST_ZERO;
      cell_done_thr_q <= `CBP_RST_DONE_THR;
      bal_overtemperature_level_q <= `CBP_RST_BAL_OVERTEMPERATURE_LEVEL;
      vcmp_ctrl_q <= `CBP_RST_ZERO;
      tcmp_ctrl_q <= `CBP_RST_ZERO;
      bal_duty_q <= `CBP_RST_ZERO;
      bal_main_q <= `CBP_RST_ZERO;
      bal_query_q <= `CBP_RST_ZERO;
    end else if (CE_I && b_wr) begin
      case (bidx_q)
        `CBP_IDX_OV_THR: ov_thr_q <= {2'd0, wd[5:0]};
        `CBP_IDX_UV_THR: uv_thr_q <= {2'd0, wd[5:0]};
        `CBP_IDX_TEMP_THR: temp_thr_q <= wd;
        `CBP_IDX_UV_EXCL_HI: excl_hi_q <= wd;
        `CBP_IDX_UV_EXCL_LO: excl_lo_q <= wd;
        `CBP_IDX_MOD_DONE_THR: mod_done_thr_q <= {2'd0, wd[5:0]};
        `CBP_IDX_MOD_TMR: mod_tmr_q <= {3'd0, wd[4:0]};
        `CBP_IDX_CELL_DONE_THR: cell_done_thr_q <= {2'd0, wd[5:0]};
        `CBP_IDX_BAL_OVERTEMPERATURE_LEVEL: bal_overtemperature_level_q <= {1'b0, wd[6:0]};
        `CBP_IDX_VCMP_CTRL: vcmp_ctrl_q <= {wd[7:3], 1'b0, wd[1:0]};
        `CBP_IDX_TCMP_CTRL: tcmp_ctrl_q <= {1'b0, wd[6:3], 1'b0, wd[1:0]};
        `CBP_IDX_BAL_DUTY: bal_duty_q <= {5'd0, wd[2:0]};
        `CBP_IDX_BAL_MAIN: bal_main_q <= {1'b0, wd[6:2], 1'b0, wd[0]};
        `CBP_IDX_BAL_QUERY: bal_query_q <= {3'd0, wd[4:1], 1'b0};
        default: ;
      endcase
    end
  end

  // Input synchronisers and the one-second tick.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      cdv_s1_q <= 16'h0000;
      cdv_s2_q <= 16'h0000;
      th_s1_q <= 7'h00;
      th_s2_q <= 7'h00;
      tick_cnt_q <= 25'd0;
      tick_q <= 1'b0;
    end else if (CE_I) begin
      cdv_s1_q <= CELL_DONE_VOLTAGE_I;
      cdv_s2_q <= cdv_s1_q;
      th_s1_q <= THERM_PCT_I;
      th_s2_q <= th_s1_q;
      tick_q <= (tick_cnt_q == TICK_CYCLES[24:0] - 25'd1);
      if (tick_cnt_q == TICK_CYCLES[24:0] - 25'd1) begin
        tick_cnt_q <= 25'd0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 25'd1;
      end
    end
  end

  // Balancing sequencer: load codes from the store, then count down once a second.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      st_q <= ST_IDLE;
      load_idx_q <= 5'd0;
      done_q <= 16'h0000;
      mod_cnt_q <= 16'd0;
      duty_cnt_q <= 11'd0;
      duty_len_q <= 11'd5;
      phase_q <= 1'b0;
      auto_q <= 1'b0;
      oten_q <= 1'b0;
      ot_hold_q <= 1'b0;
      rem_time_q <= 8'h00;
      for (i = 0; i < 16; i = i + 1) begin
        cnt_q[i] <= 16'd0;
      end
    end else if (CE_I) begin
      if (query_start) begin
        rem_time_q <= f_report(cnt_q[wd[4:1]]);
      end
      if (bal_start) begin
        st_q <= ST_LOAD;
        load_idx_q <= 5'd0;
        done_q <= 16'h0000;
        mod_cnt_q <= f_code_sec(mod_tmr_q[4:0]);
        duty_len_q <= f_duty_sec(bal_duty_q[2:0]);
        duty_cnt_q <= 11'd0;
        phase_q <= 1'b0;
        auto_q <= wd[`CBP_BIT_BAL_AUTO];
        oten_q <= wd[`CBP_BIT_BAL_OTEN];
        ot_hold_q <= 1'b0;
      end else begin
        case (st_q)
          ST_LOAD: begin
            load_idx_q <= load_idx_q + 5'd1;
            if (load_idx_q != 5'd0) begin
              cnt_q[load_cell[3:0]] <= f_code_sec(mem_rdata);
            end
            if (load_idx_q == 5'd16) begin
              st_q <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (oten_q && th_s2_q >= balance_overtemperature_pct) begin
              ot_hold_q <= 1'b1;
            end else if ({1'b0, th_s2_q} + {1'b0, cool_pct} < {1'b0, balance_overtemperature_pct}) begin
              ot_hold_q <= 1'b0;
            end
            for (i = 0; i < 16; i = i + 1) begin
              if (cnt_q[i] != 16'd0) begin
                if (auto_q && cdv_s2_q[i] && !excl_live[i]) begin
                  cnt_q[i] <= 16'd0;
                  done_q[i] <= 1'b1;
                end else if (tick_q && !paused) begin
                  cnt_q[i] <= cnt_q[i] - 16'd1;
                  if (cnt_q[i] == 16'd1) begin
                    done_q[i] <= 1'b1;
                  end
                end
              end
            end
            if (tick_q && !paused) begin
              if (mod_cnt_q != 16'd0) begin
                mod_cnt_q <= mod_cnt_q - 16'd1;
              end
              if (duty_cnt_q + 11'd1 >= duty_len_q) begin
                duty_cnt_q <= 11'd0;
                phase_q <= ~phase_q;
              end else begin
                duty_cnt_q <= duty_cnt_q + 11'd1;
              end
            end
          end
          ST_IDLE: ;
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Balancing drive outputs.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      CELL_BAL_O <= 16'h0000;
      MODULE_BAL_O <= 1'b0;
      BAL_PAUSED_O <= 1'b0;
      BAL_AUTO_O <= 1'b0;
    end else if (CE_I) begin
      for (j = 0; j < 16; j = j + 1) begin
        CELL_BAL_O[j] <= st_q[2] && !paused && (cnt_q[j] != 16'd0) && (j[0] == phase_q);
      end
      MODULE_BAL_O <= st_q[2] && !paused && (mod_cnt_q != 16'd0);
      BAL_PAUSED_O <= paused;
      BAL_AUTO_O <= auto_q;
    end
  end

  // Comparator settings are held until the matching start command captures them.
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      vmode_q <= `CBP_MODE_STOP;
      vlock_q <= 4'h0;
      tmode_q <= `CBP_MODE_STOP;
      tlock_q <= 3'h0;
      excl_cap_q <= 16'h0000;
      OV_THR_O <= 6'h3f;
      UV_THR_O <= 6'h00;
      CELL_DONE_THR_O <= 6'h3f;
      OT_PCT_O <= 7'd39;
      UT_PCT_O <= 7'd80;
      VCMP_RUN_O <= 1'b0;
      VCMP_SELFTEST_O <= 1'b0;
      VCMP_CHAN_O <= 4'h0;
      UV_MON_O <= 16'h0000;
      TCMP_RUN_O <= 1'b0;
      TCMP_SELFTEST_O <= 1'b0;
      TCMP_CHAN_O <= 3'h0;
    end else if (CE_I) begin
      if (vcmp_start) begin
        vmode_q <= wd[1:0];
        vlock_q <= wd[6:3];
        excl_cap_q <= excl_live;
        OV_THR_O <= ov_thr_q[5:0];
        UV_THR_O <= uv_thr_q[5:0];
        CELL_DONE_THR_O <= cell_done_thr_q[5:0];
      end
      if (tcmp_start) begin
        tmode_q <= wd[1:0];
        tlock_q <= wd[5:3];
        UT_PCT_O <= 7'd66 + {3'd0, temp_thr_q[7:5], 1'b0};
        OT_PCT_O <= (temp_thr_q[4:0] > 5'd29) ? 7'd39 : 7'd10 + {2'd0, temp_thr_q[4:0]};
      end
      VCMP_RUN_O <= (vmode_q != `CBP_MODE_STOP);
      VCMP_SELFTEST_O <= (vmode_q == `CBP_MODE_SELFTEST);
      UV_MON_O <= (vmode_q == `CBP_MODE_STOP) ? 16'h0000 : ~excl_cap_q;
      case (vmode_q)
        `CBP_MODE_ROBIN: VCMP_CHAN_O <= VCMP_CHAN_O + 4'h1;
        `CBP_MODE_LOCK: VCMP_CHAN_O <= vlock_q;
        default: VCMP_CHAN_O <= 4'h0;
      endcase
      TCMP_RUN_O <= (tmode_q != `CBP_MODE_STOP);
      TCMP_SELFTEST_O <= (tmode_q == `CBP_MODE_SELFTEST);
      case (tmode_q)
        `CBP_MODE_ROBIN: TCMP_CHAN_O <= TCMP_CHAN_O + 3'h1;
        `CBP_MODE_LOCK: TCMP_CHAN_O <= tlock_q;
        default: TCMP_CHAN_O <= 3'h0;
      endcase
    end
  end
endmodule

/* tb/cbp_ctrl_sva.sv */
// Port assertions for the cell balancing and protector register bank.
// Assumes CE_I stays high and HREADY_I is fed back from HREADYOUT_O.
`timescale 1ns/1ps
module cbp_ctrl_sva #(
  parameter TICK_CYCLES = 20
) (
  input wire CLK_I,
  input wire SRST_I,
  input wire CE_I,
  input wire HSEL_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire HREADY_I,
  input wire HREADYOUT_O,
  input wire HRESP_O,
  input wire [15:0] CELL_BAL_O,
  input wire BAL_PAUSED_O,
  input wire VCMP_RUN_O,
  input wire VCMP_SELFTEST_O,
  input wire [15:0] UV_MON_O,
  input wire [5:0] OV_THR_O,
  input wire [5:0] UV_THR_O,
  input wire [5:0] CELL_DONE_THR_O,
  input wire [6:0] OT_PCT_O,
  input wire [6:0] UT_PCT_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SRST_I);
  wire taken = HSEL_I && HTRANS_I[1] && HREADY_I && CE_I && HREADYOUT_O;
  reset_values_a: assert property (disable iff (1'b0)
    SRST_I ##1 SRST_I |-> OV_THR_O == 6'h3f && UV_THR_O == 6'h00 && CELL_DONE_THR_O == 6'h3f
    && OT_PCT_O == 7'h27 && UT_PCT_O == 7'h50) else $error("reset values wrong");
  ot_range_a: assert property (OT_PCT_O >= 7'h0a && OT_PCT_O <= 7'h27)
    else $error("overtemperature level out of range");
  ut_range_a: assert property (UT_PCT_O >= 7'h42 && UT_PCT_O <= 7'h50 && !UT_PCT_O[0])
    else $error("undertemperature level out of range");
  phase_split_a: assert property (!(|(CELL_BAL_O & 16'h5555) && |(CELL_BAL_O & 16'haaaa)))
    else $error("both duty phases on at once");
  pause_off_a: assert property (BAL_PAUSED_O && $past(BAL_PAUSED_O) |-> CELL_BAL_O == 16'h0000)
    else $error("balancing while paused");
  okay_resp_a: assert property (HRESP_O == 1'b0)
    else $error("bus response not okay");
  wait_state_a: assert property (taken |=> !HREADYOUT_O ##[1:20] HREADYOUT_O)
    else $error("transfer not answered in time");
  read_wait_a: assert property (taken && !HWRITE_I |=> !HREADYOUT_O [*2])
    else $error("read answered too early");
  uv_stop_a: assert property (!VCMP_RUN_O && !$past(VCMP_RUN_O) && !VCMP_SELFTEST_O
    |-> UV_MON_O == 16'h0000) else $error("cells monitored while stopped");
endmodule
bind cbp_ctrl cbp_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) cbp_ctrl_sva_i (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .CELL_BAL_O(CELL_BAL_O), .BAL_PAUSED_O(BAL_PAUSED_O), .VCMP_RUN_O(VCMP_RUN_O),
  .VCMP_SELFTEST_O(VCMP_SELFTEST_O), .UV_MON_O(UV_MON_O), .OV_THR_O(OV_THR_O), .UV_THR_O(UV_THR_O),
  .CELL_DONE_THR_O(CELL_DONE_THR_O), .OT_PCT_O(OT_PCT_O), .UT_PCT_O(UT_PCT_O));

/* tb/cbp_ctrl_test.sv */
// Self-checking bench for the cell balancing and protector register bank.
// Acts as the AHB-Lite master itself; the one-second tick is shortened to 20 cycles.
`timescale 1ns/1ps
module cbp_ctrl_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [31:0] hwdata = 32'h0;
  reg [1:0] htrans = 2'b00;
  reg [15:0] dv = 16'h0000;
  reg [6:0] th = 7'h00;
  reg [31:0] d;
  wire [31:0] hrdata;
  wire hrdy, mbal, paused, auto, vrun, vst, trun, tst;
  wire [15:0] cbal, uvmon;
  wire [3:0] vch;
  wire [2:0] tch;
  wire [6:0] otp, utp;
  integer err_total = 0;
  integer checks = 0;
  integer i;
  always #25 clk = ~clk;
  cbp_ctrl #(.TICK_CYCLES(20)) cbp_ctrl_i (
    .CLK_I(clk), .SRST_I(rst), .CE_I(1'b1), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(), .CELL_DONE_VOLTAGE_I(dv), .THERM_PCT_I(th), .CELL_BAL_O(cbal),
    .MODULE_BAL_O(mbal), .BAL_PAUSED_O(paused), .BAL_AUTO_O(auto), .VCMP_RUN_O(vrun),
    .VCMP_SELFTEST_O(vst), .VCMP_CHAN_O(vch), .OV_THR_O(), .UV_THR_O(), .UV_MON_O(uvmon),
    .CELL_DONE_THR_O(), .TCMP_RUN_O(trun), .TCMP_SELFTEST_O(tst), .TCMP_CHAN_O(tch), .OT_PCT_O(otp),
    .UT_PCT_O(utp));
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task xfer(input w, input [10:0] a, input [7:0] v);
    begin
      haddr <= {19'h0, a, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      hsel <= 1'b1;
      @(posedge clk);
      while (!hrdy) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= {24'h0, v};
      @(posedge clk);
      while (!hrdy) @(posedge clk);
      d = hrdata;
    end
  endtask
  task ckr(input [10:0] a, input [7:0] e);
    begin
      xfer(1'b0, a, 8'h00);
      checks = checks + 1;
      if (d !== {24'h0, e}) begin
        err_total = err_total + 1;
        $display("unexpected reg %h exp %h got %h", a, e, d);
      end
    end
  endtask
  task ckp(input [8*5-1:0] n, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("unexpected %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    wt(5000);
    err_total = err_total + 1;
    wrap_up;
  end
  initial begin
    wt(6);
    rst <= 1'b0;
    wt(1);
    ckr(11'h00b, 8'hfd);
    ckr(11'h009, 8'h3f);
    ckr(11'h558, 8'h00);
    xfer(1'b1, 11'h557, 8'hff);
    ckr(11'h557, 8'h00);
    xfer(1'b1, 11'h100, 8'h55);
    ckr(11'h100, 8'h00);
    ckp("otpct", 39, otp);
    ckp("utpct", 80, utp);
    $display("test reset end");
    xfer(1'b1, 11'h009, 8'h2a);
    xfer(1'b1, 11'h00a, 8'h15);
    xfer(1'b1, 11'h32a, 8'h28);
    xfer(1'b1, 11'h00c, 8'h81);
    xfer(1'b1, 11'h00d, 8'h01);
    ckr(11'h009, 8'h2a);
    ckp("ovthr", 32'h3f, cbp_ctrl_i.OV_THR_O);
    ckp("uvthr", 32'h00, cbp_ctrl_i.UV_THR_O);
    xfer(1'b1, 11'h32c, 8'h05);
    wt(4);
    ckp("ovthr", 32'h2a, cbp_ctrl_i.OV_THR_O);
    ckp("uvthr", 32'h15, cbp_ctrl_i.UV_THR_O);
    ckp("cdthr", 32'h28, cbp_ctrl_i.CELL_DONE_THR_O);
    ckp("uvmon", 16'h7efe, uvmon);
    ckr(11'h32c, 8'h01);
    xfer(1'b1, 11'h00c, 8'h00);
    xfer(1'b1, 11'h00d, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, 11'h32c, {1'b0, 4'h9, 1'b1, i[1:0]});
      wt(4);
      ckp("vself", i == 2, vst);
      if (i != 2) ckp("vrun", i != 0, vrun);
    end
    ckp("vchan", 9, vch);
    xfer(1'b1, 11'h32c, 8'h7f);
    wt(4);
    ckp("vchan", 15, vch);
    xfer(1'b1, 11'h32c, 8'h07);
    wt(4);
    ckp("vchan", 0, vch);
    $display("test voltage end");
    xfer(1'b1, 11'h00b, 8'h05);
    wt(4);
    ckp("otpct", 39, otp);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, 11'h32d, {5'h00, 1'b1, i[1:0]});
      wt(4);
      ckp("tself", i == 2, tst);
      if (i != 2) ckp("trun", i != 0, trun);
    end
    ckp("otpct", 15, otp);
    ckp("utpct", 66, utp);
    xfer(1'b1, 11'h32d, 8'h2f);
    wt(4);
    ckp("tchan", 5, tch);
    xfer(1'b1, 11'h00b, 8'hff);
    xfer(1'b1, 11'h32d, 8'h05);
    wt(4);
    ckp("otpct", 39, otp);
    ckp("utpct", 80, utp);
    $display("test temperature end");
    for (i = 0; i < 16; i = i + 1) xfer(1'b1, 11'h318 + i[10:0], 8'h00);
    xfer(1'b1, 11'h327, 8'h01);
    xfer(1'b1, 11'h329, 8'h01);
    xfer(1'b1, 11'h32f, 8'h02);
    wt(40);
    ckp("cbal", 16'h0001, cbal);
    ckp("mbal", 1, mbal);
    xfer(1'b1, 11'h330, 8'h01);
    ckr(11'h558, 8'h02);
    wt(118);
    ckp("cbal", 16'h0000, cbal);
    wt(130);
    ckr(11'h557, 8'h01);
    ckp("mbal", 0, mbal);
    xfer(1'b1, 11'h32f, 8'h02);
    ckr(11'h557, 8'h00);
    xfer(1'b1, 11'h32f, 8'h40);
    wt(4);
    ckp("pause", 1, paused);
    ckp("cbal", 16'h0000, cbal);
    xfer(1'b1, 11'h32f, 8'h00);
    wt(4);
    ckp("pause", 0, paused);
    ckp("cbal", 16'h0001, cbal);
    dv <= 16'h0001;
    xfer(1'b1, 11'h32f, 8'h03);
    wt(30);
    ckp("auto", 1, auto);
    ckr(11'h557, 8'h01);
    $display("test balancing end");
    dv <= 16'h0000;
    th <= 7'h0e;
    xfer(1'b1, 11'h32b, 8'h12);
    xfer(1'b1, 11'h32f, 8'h12);
    wt(30);
    ckp("pause", 1, paused);
    th <= 7'h0c;
    wt(6);
    ckp("pause", 1, paused);
    th <= 7'h0b;
    wt(6);
    ckp("pause", 0, paused);
    th <= 7'h17;
    xfer(1'b1, 11'h32b, 8'h0f);
    xfer(1'b1, 11'h32f, 8'h12);
    wt(30);
    ckp("pause", 0, paused);
    th <= 7'h18;
    wt(6);
    ckp("pause", 1, paused);
    $display("test thermal end");
    xfer(1'b1, 11'h318, 8'h11);
    xfer(1'b1, 11'h319, 8'h1f);
    xfer(1'b1, 11'h31a, 8'h10);
    ckr(11'h318, 8'h11);
    xfer(1'b1, 11'h32f, 8'h02);
    wt(20);
    xfer(1'b1, 11'h330, 8'h1f);
    ckr(11'h558, 8'h9e);
    xfer(1'b1, 11'h330, 8'h1d);
    ckr(11'h558, 8'hf8);
    xfer(1'b1, 11'h330, 8'h1b);
    ckr(11'h558, 8'h98);
    $display("test timer end");
    wrap_up;
  end
endmodule
